// [core/seq_defs.svh]
// offsets, field positions, reset values and timing counts of the buck power sequencer
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define CLK_PERIOD_NS   10
`define MS_TIME_NS      1000000
`define MS_CYCLES       ((`MS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOT_TIME_NS    1400000
`define BOOT_CYCLES     ((`BOOT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CROWBAR_TIME_NS 32000
`define CROWBAR_CYCLES  ((`CROWBAR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEBOUNCE_MS     4'ha
`define RETRY_MS        6'h02
`define FLOOR_CODE      10'h0d0
// global registers, addr[7:6] = 2'b00
`define A_CTRL          4'h0
`define A_CFG           4'h1
`define A_FLAGS         4'h2
`define A_MASK          4'h3
`define A_WINDOW        4'h4
`define A_STATE         4'h5
// per output registers, addr[7:6] = 2'b01, addr[5:4] = output
`define F_RAMP_A        4'h0
`define F_RAMP_B        4'h1
`define F_TGT_HI        4'h2
`define F_TGT_LO        4'h3
`define F_START_DLY     4'h4
`define F_STOP_DLY      4'h5
// cfg bits
`define CFG_PINFN_MSB   2
`define CFG_ALIVE_POL   3
`define CFG_ALERT_HI    4
`define CFG_ALERT_OD    5
`define CFG_DISCHARGE   6
`define PINFN_EN_PINS   3'h1
// flag bit groups
`define FL_OC           0
`define FL_OV           4
`define FL_UV           8
`define FL_OT           12
`define FL_WDOG         13
`define CFG_RST         7'h60
`define MASK_RST        14'h3fff
`define WINDOW_RST      10'h0d0
`define RAMP_RST        6'h00
`define DLY_RST         6'h00
`endif

// [core/seq_pkg.sv]
// types shared by the buck power sequencer
package seq_pkg;
  typedef enum logic [3:0] {
    SEQ_SHUT = 4'h1, SEQ_BOOT = 4'h2, SEQ_RUN = 4'h4, SEQ_DOWN = 4'h8
  } seq_st_e;
  typedef enum logic [7:0] {
    CH_OFF = 8'h01, CH_WAIT_ON = 8'h02, CH_RAMP_UP = 8'h04, CH_ON = 8'h08,
    CH_WAIT_OFF = 8'h10, CH_RAMP_DN = 8'h20, CH_FAULT = 8'h40, CH_CROWBAR = 8'h80
  } ch_st_e;
  typedef struct packed {
    logic       conv_on;
    logic       hiz;
    logic       low_side_on;
    logic       discharge_on;
    logic [2:0] slew_sel;
    logic [9:0] dac_code;
  } chan_out_s;
  typedef struct packed {
    logic [2:0] shutdown_slew_sel;
    logic [2:0] powerup_slew_sel;
  } ramp_config_a_s;
  typedef struct packed {
    logic [2:0] scale_fall_slew_sel;
    logic [2:0] scale_rise_slew_sel;
  } ramp_config_b_s;
  typedef struct packed {
    ramp_config_a_s ramp_config_a;
    ramp_config_b_s ramp_config_b;
    logic [5:0]     startup_delay;
    logic [5:0]     shutdown_delay;
  } chan_cfg_s;
endpackage : seq_pkg

// [core/buck_power_sequencer.sv]
// sequencing, target commit, watchdog restore, alert and fault handling for four buck outputs
// Functional notes
// - power-up slew selection applies only during the power-up ramp
// - shutdown slew selection applies while an output ramps down in shutdown
// - separate rise and fall slews apply to voltage-scaling moves of an active output
// - 10-bit target split high/low; it takes effect only on the low write
// - chip enable rising starts bias, loads stored config, then manual or auto start
// - manual start: host sets enable bit, output soft-starts at power-up slew
// - auto start waits each output's 0..63 ms delay after boot; manual ignores it
// - configuration load lasts the 1.4 ms boot interval before delays count
// - manual power-down by bit or enable pin ramps only that output, no delay
// - chip enable low ramps all outputs down with shutdown delay and slew
// - the down ramp is controlled only to about 250 mV
// - no weak discharge when the disable came from chip enable falling
// - enable bit 1 to 0 with chip enable high uses the weak discharge bit
// - host-alive lost over 10 ms restores stored slot-zero targets
// - restore acts on all four outputs; host-alive polarity is programmable
// - boot loads all targets from stored configuration
// - maskable alert output, polarity and open drain selectable
// - over-temperature shuts all converters down, re-enables when it clears
// - overcurrent disables the converter in high impedance and retries periodically
// - overvoltage crowbars 32 to 64 us (here a fixed 32 us, CROWBAR_CYCLES), shuts down and retries
// - undervoltage shuts down and restarts until the fault clears
// - over/undervoltage judged in a window around the target code
`timescale 1ns/1ps
`include "seq_defs.svh"
module buck_power_sequencer #(
  parameter int unsigned MS_CYCLES   = `MS_CYCLES,
  parameter int unsigned BOOT_CYCLES = `BOOT_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                chip_en,
  input  wire logic                host_alive_input,
  input  wire logic [3:0]          en_pin,
  input  wire logic                over_temp,
  input  wire logic [3:0]          oc_flag,
  input  wire logic [3:0][9:0]     vout_code,
  input  wire logic [3:0]          ramp_done,
  input  wire logic                otp_auto_start,
  input  wire logic [3:0]          otp_enable,
  input  wire logic [3:0][9:0]     otp_target,
  input  wire logic [7:0]          addr,
  input  wire logic [15:0]         wr_data,
  input  wire logic                wr_stb,
  input  wire logic                rd_stb,
  output logic [15:0]              rd_data,
  output seq_pkg::chan_out_s       chan_out [4],
  output logic                     bias_on,
  output logic                     alert_o,
  output logic                     alert_oe
);
  logic                   rst_meta_reg;
  logic                   rst_sync_reg;
  seq_pkg::seq_st_e       seq_reg;
  logic [17:0]            boot_cnt_reg;
  logic [16:0]            ms_cnt_reg;
  logic                   ms_tick_reg;
  logic [3:0]             en_bits_reg;
  logic                   auto_reg;
  logic [6:0]             cfg_reg;
  logic [13:0]            mask_reg;
  logic [13:0]            flags_reg;
  logic [13:0]            flags_next;
  logic [9:0]             window_reg;
  seq_pkg::chan_cfg_s     ccfg_reg [4];
  logic [7:0]             hi_reg [4];
  logic [9:0]             tgt_reg [4];
  logic [3:0]             wd_cnt_reg;
  logic                   wd_fire_reg;
  seq_pkg::ch_st_e        st_reg [4];
  logic [3:0]             want;
  logic [3:0]             oc_e;
  logic [3:0]             ov_e;
  logic [3:0]             uv_e;
  logic [3:0]             is_off;
  logic                   all_off;
  logic                   lost;
  logic                   alert_act;
  logic                   alert_lvl;
  logic [15:0]            rd_mux;
  logic                   wr_glob;

  function automatic logic ch_hit(input logic [7:0] a, input logic [1:0] c, input logic [3:0] f);
    ch_hit = (a[7:6] == 2'b01) && (a[5:4] == c) && (a[3:0] == f);
  endfunction : ch_hit

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // free-running millisecond timebase
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ms_cnt_reg  <= '0;
      ms_tick_reg <= 1'b0;
    end else begin
      ms_tick_reg <= (ms_cnt_reg == 17'(MS_CYCLES - 1));
      ms_cnt_reg  <= (ms_cnt_reg == 17'(MS_CYCLES - 1)) ? '0 : ms_cnt_reg + 17'h1;
    end
  end

  assign all_off = &is_off;

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      seq_reg      <= seq_pkg::SEQ_SHUT;
      boot_cnt_reg <= '0;
      bias_on      <= 1'b0;
    end else begin
      unique case (seq_reg)
        seq_pkg::SEQ_SHUT: if (chip_en) begin
          seq_reg      <= seq_pkg::SEQ_BOOT;
          boot_cnt_reg <= '0;
          bias_on      <= 1'b1;
        end
        seq_pkg::SEQ_BOOT: begin
          boot_cnt_reg <= boot_cnt_reg + 18'h1;
          if (!chip_en) seq_reg <= seq_pkg::SEQ_DOWN;
          else if (boot_cnt_reg == 18'(BOOT_CYCLES - 1)) seq_reg <= seq_pkg::SEQ_RUN;
        end
        seq_pkg::SEQ_RUN: if (!chip_en) seq_reg <= seq_pkg::SEQ_DOWN;
        seq_pkg::SEQ_DOWN: if (all_off) begin
          seq_reg <= seq_pkg::SEQ_SHUT;
          bias_on <= 1'b0;
        end
      endcase
    end
  end

  assign wr_glob = wr_stb && (addr[7:6] == 2'b00);

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      en_bits_reg <= '0;
      auto_reg    <= 1'b0;
      cfg_reg     <= `CFG_RST;
      mask_reg    <= `MASK_RST;
      window_reg  <= `WINDOW_RST;
    end else begin
      if (seq_reg == seq_pkg::SEQ_BOOT) begin
        en_bits_reg <= otp_enable;
        auto_reg    <= otp_auto_start;
      end else if (wr_glob && addr[3:0] == `A_CTRL) en_bits_reg <= wr_data[3:0];
      if (wr_glob && addr[3:0] == `A_CFG) cfg_reg <= wr_data[6:0];
      if (wr_glob && addr[3:0] == `A_MASK) mask_reg <= wr_data[13:0];
      if (wr_glob && addr[3:0] == `A_WINDOW) window_reg <= wr_data[9:0];
    end
  end

  // host-alive lost for more than the debounce time restores slot-zero targets
  assign lost = (host_alive_input == cfg_reg[`CFG_ALIVE_POL]);
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      wd_cnt_reg  <= '0;
      wd_fire_reg <= 1'b0;
    end else begin
      wd_fire_reg <= 1'b0;
      if (!lost || seq_reg != seq_pkg::SEQ_RUN) wd_cnt_reg <= '0;
      else if (ms_tick_reg && wd_cnt_reg <= `DEBOUNCE_MS) begin
        wd_cnt_reg <= wd_cnt_reg + 4'h1;
        if (wd_cnt_reg == `DEBOUNCE_MS) wd_fire_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      for (int i = 0; i < 4; i++) begin
        hi_reg[i]   <= '0;
        tgt_reg[i]  <= '0;
        ccfg_reg[i] <= {`RAMP_RST, `RAMP_RST, `DLY_RST, `DLY_RST};
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (seq_reg == seq_pkg::SEQ_BOOT || wd_fire_reg) begin
          tgt_reg[i] <= otp_target[i];
          hi_reg[i]  <= otp_target[i][9:2];
        end else begin
          if (wr_stb && ch_hit(addr, 2'(i), `F_TGT_HI)) hi_reg[i] <= wr_data[7:0];
          if (wr_stb && ch_hit(addr, 2'(i), `F_TGT_LO)) tgt_reg[i] <= {hi_reg[i], wr_data[1:0]};
        end
        if (wr_stb && ch_hit(addr, 2'(i), `F_RAMP_A)) ccfg_reg[i].ramp_config_a <= wr_data[5:0];
        if (wr_stb && ch_hit(addr, 2'(i), `F_RAMP_B)) ccfg_reg[i].ramp_config_b <= wr_data[5:0];
        if (wr_stb && ch_hit(addr, 2'(i), `F_START_DLY)) ccfg_reg[i].startup_delay <= wr_data[5:0];
        if (wr_stb && ch_hit(addr, 2'(i), `F_STOP_DLY)) ccfg_reg[i].shutdown_delay <= wr_data[5:0];
      end
    end
  end

  // sticky flags: a set in the clearing cycle survives the write-one clear
  always_comb begin
    flags_next = flags_reg;
    if (wr_glob && addr[3:0] == `A_FLAGS) flags_next = flags_next & ~wr_data[13:0];
    flags_next = flags_next | {wd_fire_reg, over_temp, uv_e, ov_e, oc_e};
    if (seq_reg == seq_pkg::SEQ_DOWN && all_off) flags_next = '0;
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) flags_reg <= '0;
    else flags_reg <= flags_next;
  end

  assign alert_act = |(flags_reg & mask_reg);
  assign alert_lvl = alert_act ^ ~cfg_reg[`CFG_ALERT_HI];
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      alert_o  <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      alert_o  <= cfg_reg[`CFG_ALERT_OD] ? 1'b0 : alert_lvl;
      alert_oe <= cfg_reg[`CFG_ALERT_OD] ? ~alert_lvl : 1'b1;
    end
  end

  always_comb begin
    rd_mux = '0;
    if (addr[7:6] == 2'b00) begin
      case (addr[3:0])
        `A_CTRL:   rd_mux = {12'h000, en_bits_reg};
        `A_CFG:    rd_mux = {9'h000, cfg_reg};
        `A_FLAGS:  rd_mux = {2'h0, flags_reg};
        `A_MASK:   rd_mux = {2'h0, mask_reg};
        `A_WINDOW: rd_mux = {6'h00, window_reg};
        `A_STATE:  rd_mux = {8'h00, chan_out[3].conv_on, chan_out[2].conv_on,
                             chan_out[1].conv_on, chan_out[0].conv_on, seq_reg};
        default:   rd_mux = '0;
      endcase
    end else if (addr[7:6] == 2'b01) begin
      case (addr[3:0])
        `F_RAMP_A:    rd_mux = {10'h000, ccfg_reg[addr[5:4]].ramp_config_a};
        `F_RAMP_B:    rd_mux = {10'h000, ccfg_reg[addr[5:4]].ramp_config_b};
        `F_TGT_HI:    rd_mux = {8'h00, tgt_reg[addr[5:4]][9:2]};
        `F_TGT_LO:    rd_mux = {14'h0000, tgt_reg[addr[5:4]][1:0]};
        `F_START_DLY: rd_mux = {10'h000, ccfg_reg[addr[5:4]].startup_delay};
        `F_STOP_DLY:  rd_mux = {10'h000, ccfg_reg[addr[5:4]].shutdown_delay};
        default:      rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) rd_data <= '0;
    else rd_data <= rd_stb ? rd_mux : '0;
  end

  for (genvar i = 0; i < 4; i++) begin : g_ch
    seq_pkg::ch_st_e    st_next;
    seq_pkg::chan_out_s out_next;
    logic [5:0]         cnt_reg;
    logic [5:0]         cnt_next;
    logic [11:0]        cb_reg;
    logic [11:0]        cb_next;
    logic               man_reg;
    logic               man_next;
    logic               hiz_reg;
    logic               hiz_next;
    logic               fresh_reg;
    logic               oc_ev;
    logic               ov_ev;
    logic               uv_ev;
    logic               ov_hit;
    logic               uv_hit;
    logic               down;
    logic [18:0]        flt_cyc_reg;

    assign want[i] = (seq_reg == seq_pkg::SEQ_RUN) && !over_temp && en_bits_reg[i] &&
                     (cfg_reg[`CFG_PINFN_MSB:0] != `PINFN_EN_PINS || en_pin[i]);
    assign down    = (seq_reg == seq_pkg::SEQ_DOWN);
    assign ov_hit  = ramp_done[i] && ({1'b0, vout_code[i]} > {1'b0, tgt_reg[i]} + {1'b0, window_reg});
    assign uv_hit  = ramp_done[i] && ({1'b0, vout_code[i]} + {1'b0, window_reg} < {1'b0, tgt_reg[i]});
    assign is_off[i] = (st_reg[i] == seq_pkg::CH_OFF);
    assign oc_e[i] = oc_ev;
    assign ov_e[i] = ov_ev;
    assign uv_e[i] = uv_ev;

    always_comb begin
      st_next  = st_reg[i];
      cnt_next = cnt_reg;
      cb_next  = '0;
      man_next = man_reg;
      hiz_next = hiz_reg;
      oc_ev    = 1'b0;
      ov_ev    = 1'b0;
      uv_ev    = 1'b0;
      unique case (st_reg[i])
        seq_pkg::CH_OFF: if (want[i]) begin
          man_next = 1'b0;
          if (auto_reg && fresh_reg) begin
            st_next  = seq_pkg::CH_WAIT_ON;
            cnt_next = ccfg_reg[i].startup_delay;
          end else st_next = seq_pkg::CH_RAMP_UP;
        end
        seq_pkg::CH_WAIT_ON: begin
          if (!want[i]) st_next = seq_pkg::CH_OFF;
          else if (cnt_reg == 6'h00) st_next = seq_pkg::CH_RAMP_UP;
          else if (ms_tick_reg) cnt_next = cnt_reg - 6'h01;
        end
        seq_pkg::CH_RAMP_UP, seq_pkg::CH_ON: begin
          if (oc_flag[i]) begin
            st_next  = seq_pkg::CH_FAULT;
            hiz_next = 1'b1;
            cnt_next = `RETRY_MS;
            oc_ev    = 1'b1;
          end else if (down) begin
            st_next  = seq_pkg::CH_WAIT_OFF;
            cnt_next = ccfg_reg[i].shutdown_delay;
          end else if (over_temp) st_next = seq_pkg::CH_OFF;
          else if (!want[i]) begin
            st_next  = seq_pkg::CH_RAMP_DN;
            man_next = 1'b1;
          end else if (st_reg[i] == seq_pkg::CH_RAMP_UP) begin
            if (ramp_done[i]) st_next = seq_pkg::CH_ON;
          end else if (ov_hit) begin
            st_next = seq_pkg::CH_CROWBAR;
            ov_ev   = 1'b1;
          end else if (uv_hit) begin
            st_next  = seq_pkg::CH_FAULT;
            cnt_next = `RETRY_MS;
            uv_ev    = 1'b1;
          end
        end
        seq_pkg::CH_WAIT_OFF: begin
          man_next = 1'b0;
          if (cnt_reg == 6'h00) st_next = seq_pkg::CH_RAMP_DN;
          else if (ms_tick_reg) cnt_next = cnt_reg - 6'h01;
        end
        seq_pkg::CH_RAMP_DN: if (ramp_done[i]) st_next = seq_pkg::CH_OFF;
        seq_pkg::CH_FAULT: begin
          if (seq_reg != seq_pkg::SEQ_RUN) begin
            st_next  = seq_pkg::CH_OFF;
            hiz_next = 1'b0;
          end else if (cnt_reg == 6'h00) begin
            hiz_next = 1'b0;
            st_next  = want[i] ? seq_pkg::CH_RAMP_UP : seq_pkg::CH_OFF;
          end else if (ms_tick_reg) cnt_next = cnt_reg - 6'h01;
        end
        seq_pkg::CH_CROWBAR: begin
          if (cb_reg == 12'(`CROWBAR_CYCLES - 1)) begin
            st_next  = seq_pkg::CH_FAULT;
            cnt_next = `RETRY_MS;
          end else cb_next = cb_reg + 12'h001;
        end
      endcase
    end

    // outputs follow the next state so the analog side sees them with the state change
    always_comb begin
      out_next              = chan_out[i];
      out_next.conv_on      = st_next inside {seq_pkg::CH_RAMP_UP, seq_pkg::CH_ON,
                                              seq_pkg::CH_WAIT_OFF, seq_pkg::CH_RAMP_DN};
      out_next.hiz          = (st_next == seq_pkg::CH_FAULT) && hiz_next;
      out_next.low_side_on  = (st_next == seq_pkg::CH_CROWBAR);
      out_next.discharge_on = (st_next == seq_pkg::CH_OFF) && man_next && !down &&
                              cfg_reg[`CFG_DISCHARGE];
      unique case (st_next)
        seq_pkg::CH_RAMP_UP: begin
          out_next.slew_sel = ccfg_reg[i].ramp_config_a.powerup_slew_sel;
          out_next.dac_code = tgt_reg[i];
        end
        seq_pkg::CH_ON, seq_pkg::CH_WAIT_OFF: begin
          if (tgt_reg[i] > chan_out[i].dac_code)
            out_next.slew_sel = ccfg_reg[i].ramp_config_b.scale_rise_slew_sel;
          else if (tgt_reg[i] < chan_out[i].dac_code)
            out_next.slew_sel = ccfg_reg[i].ramp_config_b.scale_fall_slew_sel;
          out_next.dac_code = tgt_reg[i];
        end
        seq_pkg::CH_RAMP_DN: begin
          out_next.slew_sel = ccfg_reg[i].ramp_config_a.shutdown_slew_sel;
          out_next.dac_code = `FLOOR_CODE;
        end
        default: out_next.dac_code = '0;
      endcase
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
        st_reg[i]   <= seq_pkg::CH_OFF;
        chan_out[i] <= '0;
        cnt_reg     <= '0;
        cb_reg      <= '0;
        man_reg     <= 1'b0;
        hiz_reg     <= 1'b0;
        fresh_reg   <= 1'b0;
      end else begin
        st_reg[i]   <= st_next;
        chan_out[i] <= out_next;
        cnt_reg     <= cnt_next;
        cb_reg      <= cb_next;
        man_reg     <= man_next;
        hiz_reg     <= hiz_next;
        if (seq_reg == seq_pkg::SEQ_BOOT) fresh_reg <= 1'b1;
        else if (st_reg[i] != seq_pkg::CH_OFF) fresh_reg <= 1'b0;
      end
    end

    // helper for the retry bound: a delay range cannot reach across milliseconds of clock cycles
    always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) flt_cyc_reg <= '0;
      else if (st_reg[i] == seq_pkg::CH_FAULT) flt_cyc_reg <= flt_cyc_reg + 19'h00001;
      else flt_cyc_reg <= '0;
    end

    sequence s_crowbar_exit;
      st_reg[i] == seq_pkg::CH_CROWBAR ##1 st_reg[i] == seq_pkg::CH_FAULT;
    endsequence
    a_crowbar_len: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      s_crowbar_exit |-> $past(cb_reg, 1) == 12'(`CROWBAR_CYCLES - 1))
      else $error("crowbar length wrong");
    a_lo_commit: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      wr_stb && ch_hit(addr, 2'(i), `F_TGT_LO) && seq_reg == seq_pkg::SEQ_RUN && !wd_fire_reg
      |=> tgt_reg[i] == {$past(hi_reg[i]), $past(wr_data[1:0])})
      else $error("low write did not commit target");
    a_hi_hold: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      wr_stb && ch_hit(addr, 2'(i), `F_TGT_HI) && seq_reg == seq_pkg::SEQ_RUN && !wd_fire_reg
      |=> $stable(tgt_reg[i]))
      else $error("high write changed target");
    a_pup_slew: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      st_reg[i] == seq_pkg::CH_RAMP_UP && $stable(ccfg_reg[i])
      |-> chan_out[i].slew_sel == ccfg_reg[i].ramp_config_a.powerup_slew_sel)
      else $error("power-up slew not applied");
    a_manual_start: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      st_reg[i] == seq_pkg::CH_OFF && want[i] && !auto_reg |=> st_reg[i] == seq_pkg::CH_RAMP_UP)
      else $error("manual start was delayed");
    a_oc_hiz: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      st_reg[i] == seq_pkg::CH_ON && oc_flag[i]
      |=> chan_out[i].hiz && !chan_out[i].conv_on)
      else $error("overcurrent not handled");
    a_retry_bound: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      flt_cyc_reg < 19'((`RETRY_MS + 1) * MS_CYCLES))
      else $error("fault retry never came");
    a_ot_off: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      over_temp && seq_reg == seq_pkg::SEQ_RUN && st_reg[i] == seq_pkg::CH_ON && !oc_flag[i]
      |=> !chan_out[i].conv_on)
      else $error("over-temperature did not shut output");
    a_ce_no_disch: assert property (@(posedge clk) disable iff (!rst_sync_reg)
      seq_reg == seq_pkg::SEQ_DOWN && $past(seq_reg) == seq_pkg::SEQ_DOWN |-> !chan_out[i].discharge_on)
      else $error("discharge on during chip shutdown");
  end

  a_boot_len: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    seq_reg == seq_pkg::SEQ_RUN && $past(seq_reg) == seq_pkg::SEQ_BOOT
    |-> $past(boot_cnt_reg) == 18'(BOOT_CYCLES - 1))
    else $error("boot interval wrong");
  a_wdog_restore: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    wd_fire_reg |=> tgt_reg[0] == $past(otp_target[0]) && tgt_reg[3] == $past(otp_target[3]))
    else $error("watchdog restore missing");
endmodule : buck_power_sequencer

// [verif/host_side_model.sv]
// far-side model: each output settles on its commanded code one cycle late
`timescale 1ns/1ps
module host_side_model (
  input  wire logic                clk,
  input  wire seq_pkg::chan_out_s  chan_out [4],
  output logic [3:0][9:0]          vout_code,
  output logic [3:0]               ramp_done
);
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) vout_code[i] <= chan_out[i].conv_on ? chan_out[i].dac_code : 10'h000;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) ramp_done[i] = vout_code[i] === chan_out[i].dac_code;
  end
endmodule : host_side_model

// [verif/tb_buck_power_sequencer.sv]
// bench: reset values, boot, manual start, target commit, faults, watchdog, chip-enable shutdown
`timescale 1ns/1ps
module tb_buck_power_sequencer;
  logic               clk = 0, rst_n = 0, chip_en = 0, alive = 1, wr_stb = 0, rd_stb = 0, rd_seen = 0;
  logic               over_temp = 0;
  logic [3:0]         otp_en = 4'h0, oc = 4'h0, ramp_done;
  logic [7:0]         addr = 8'h00, lfsr = 8'h37;
  logic [15:0]        wr_data = 16'h0000, rd_data;
  logic [3:0][9:0]    otp_t = {4{10'h120}}, vout_code;
  logic               bias_on, alert_o, alert_oe;
  logic [15:0]        exp_q [$];
  int                 miscompares = 0, compares = 0;
  seq_pkg::chan_out_s chan_out [4];
  buck_power_sequencer #(.MS_CYCLES(20), .BOOT_CYCLES(30)) dut (.clk(clk), .rst_n(rst_n), .chip_en(chip_en),
    .host_alive_input(alive), .en_pin(4'h0), .over_temp(over_temp), .oc_flag(oc), .vout_code(vout_code),
    .ramp_done(ramp_done), .otp_auto_start(1'b0), .otp_enable(otp_en), .otp_target(otp_t), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .chan_out(chan_out),
    .bias_on(bias_on), .alert_o(alert_o), .alert_oe(alert_oe));
  host_side_model partner (.clk(clk), .chan_out(chan_out), .vout_code(vout_code), .ramp_done(ramp_done));
  initial forever #5 clk = ~clk;
  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : next_rand
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // strobes are only ever set here, once per cycle, so back-to-back calls never double-drive
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
    wr_stb <= w;
    rd_stb <= r;
    addr <= a;
    wr_data <= d;
    if (r) exp_q.push_back(e);
    @(posedge clk);
    #1;
  endtask : bus
  task automatic idle(input int n);
    repeat (n) bus(0, 0, 8'h00, '0, '0);
  endtask : idle
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    rd_seen <= rd_stb;
    if (rd_seen) check(rd_data, exp_q.pop_front());
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    logic [9:0] code;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    idle(3);
    bus(0, 1, 8'h01, '0, 16'h0060);
    bus(0, 1, 8'h03, '0, 16'h3fff);
    bus(0, 1, 8'h04, '0, 16'h00d0);
    bus(0, 1, 8'h80, '0, 16'h0000);
    bus(0, 1, 8'h05, '0, 16'h0001);
    idle(2);
    $display("test reset done");
    chip_en <= 1'b1;
    idle(12);
    check(16'(bias_on), 16'h0001);
    bus(0, 1, 8'h05, '0, 16'h0002);
    idle(25);
    bus(0, 1, 8'h05, '0, 16'h0004);
    bus(1, 0, 8'h50, 16'h002b, '0);
    bus(1, 0, 8'h51, 16'h0032, '0);
    bus(1, 0, 8'h00, 16'h0002, '0);
    for (int i = 0; i < 8 && chan_out[1].conv_on !== 1'b1; i++) idle(1);
    check(16'(chan_out[1].slew_sel), 16'h0003);
    check(16'(chan_out[1].dac_code), 16'h0120);
    idle(5);
    lfsr = next_rand(lfsr);
    code = {lfsr, 2'b01};
    bus(1, 0, 8'h52, {8'h00, lfsr}, '0);
    idle(1);
    check(16'(chan_out[1].dac_code), 16'h0120);
    bus(1, 0, 8'h53, 16'h0001, '0);
    idle(1);
    check(16'(chan_out[1].dac_code), 16'(code));
    check(16'(chan_out[1].slew_sel), code > 10'h120 ? 16'h0002 : 16'h0006);
    $display("test commit done");
    over_temp <= 1'b1;
    idle(2);
    check(16'(chan_out[1].conv_on), 16'h0000);
    check(16'({alert_oe, alert_o}), 16'h0002);
    bus(1, 0, 8'h02, 16'h1000, '0);
    bus(0, 1, 8'h02, '0, 16'h1000);
    over_temp <= 1'b0;
    bus(1, 0, 8'h02, 16'h1000, '0);
    check(16'(chan_out[1].conv_on), 16'h0001);
    bus(0, 1, 8'h02, '0, 16'h0000);
    check(16'({alert_oe, alert_o}), 16'h0000);
    alive <= 1'b0;
    idle(240);
    check(16'(chan_out[1].dac_code), 16'h0120);
    check(16'(chan_out[1].slew_sel), code > 10'h120 ? 16'h0006 : 16'h0002);
    alive <= 1'b1;
    oc <= 4'h2;
    idle(2);
    check(16'({chan_out[1].hiz, chan_out[1].conv_on}), 16'h0002);
    oc <= 4'h0;
    idle(70);
    check(16'({chan_out[1].hiz, chan_out[1].conv_on}), 16'h0001);
    bus(0, 1, 8'h02, '0, 16'h2002);
    bus(1, 0, 8'h00, 16'h0000, '0);
    idle(1);
    check(16'(chan_out[1].slew_sel), 16'h0005);
    idle(3);
    check(16'({chan_out[1].discharge_on, chan_out[1].conv_on}), 16'h0002);
    bus(1, 0, 8'h00, 16'h0002, '0);
    $display("test fault done");
    chip_en <= 1'b0;
    for (int i = 0; i < 60 && chan_out[1].dac_code !== 10'h0d0; i++) idle(1);
    check(16'(chan_out[1].slew_sel), 16'h0005);
    check(16'(chan_out[1].discharge_on), 16'h0000);
    for (int i = 0; i < 60 && bias_on !== 1'b0; i++) idle(1);
    check(16'({chan_out[1].discharge_on, chan_out[1].conv_on}), 16'h0000);
    bus(0, 1, 8'h05, '0, 16'h0001);
    idle(2);
    $display("test shutdown done");
    close_out();
  end
endmodule : tb_buck_power_sequencer
